// ===== design/vic_irq_ctrl.sv
// Two-level vectored interrupt controller with AXI4-Lite register access
//
// Notes on behaviour
// - Every source gated by its own enable; global enable clear masks all.
// - Vectors 0003H, 000BH, 0013H, 001BH, 0023H, 0033H; slot 002BH has no source.
// - One priority bit per source selects low (clear) or high (set) level.
// - Simultaneous requests of different levels: the high level wins.
// - Equal level: fixed polling order, external 0 first, low-voltage last.
// - Low routine preempted only by high request; high routine never preempted.
// - Each external request selects level or edge trigger by its own bit.
// - Vectoring clears an external flag only in edge mode; level mode follows pin.
// - Timer flags set on rollover and cleared when their routine is vectored.
// - Serial request is OR of receive and transmit done; vectoring keeps both.
// - Software writes to request flags act exactly like hardware updates; here a level-mode external flag follows the pin, not the write.
// - No acknowledge during equal/higher routine, mid-instruction, after return/enable write, self-programming.
// - Acknowledge is a six-cycle call pushing the counter, then loading the vector.
// - Return from interrupt ends the current level in progress.
// - Edge mode sets on high sample then low; level mode requests on low.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps

module vic_irq_ctrl
	import vic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [VIC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [VIC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext0RequestPinN,
	input wire logic ext1RequestPinN,
	input wire vic_periph_t periph,
	input wire vic_core_in_t core,
	output vic_core_out_t coreOut
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic isMapped(input logic [VIC_ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		isMapped = (addr[VIC_ADDR_W-1:10] == '0) && (idx == VIC_IDX_PWR || idx == VIC_IDX_TMR ||
			idx == VIC_IDX_SER || idx == VIC_IDX_IEN || idx == VIC_IDX_IPR || idx == VIC_IDX_STAT);
	endfunction

	// Lowest index wins: polling order within one level
	function automatic logic [2:0] firstSet(input logic [VIC_NUM_SRC-1:0] req);
		firstSet = 3'h0;
		for (int i = VIC_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				firstSet = 3'(i);
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers and state

	logic [7:0] pwr_q, pwr_d;
	logic [7:0] tmr_q, tmr_d;
	logic [7:0] ser_q, ser_d;
	logic [7:0] ien_q, ipr_q;
	logic ext0Prev_q, ext1Prev_q;
	logic inProgLow_q, inProgHigh_q;
	logic holdOff_q;
	vic_state_t state_q;
	logic [2:0] callCnt_q;
	logic [15:0] vector_q;
	logic [15:0] pcSave_q;
	logic callStart_q, callDone_q, pushValid_q;
	logic [7:0] pushByte_q;

	logic awHeld_q, wHeld_q;
	logic [VIC_ADDR_W-1:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
	wire [7:0] wIdx = awAddr_q[9:2];
	wire wMapped = isMapped(awAddr_q);
	wire wLane0 = doWrite && wMapped && wStrb_q[0];
	wire [7:0] wByte = wData_q[7:0];
	wire wrPwr = wLane0 && wIdx == VIC_IDX_PWR;
	wire wrTmr = wLane0 && wIdx == VIC_IDX_TMR;
	wire wrSer = wLane0 && wIdx == VIC_IDX_SER;
	wire wrIen = wLane0 && wIdx == VIC_IDX_IEN;
	wire wrIpr = wLane0 && wIdx == VIC_IDX_IPR;
	wire readTake = s_axi_arvalid && !rvalid_q;
	wire [7:0] rIdx = s_axi_araddr[9:2];
	wire [7:0] statByte = {5'h00, inProgHigh_q, inProgLow_q, state_q == VIC_ST_CALL};
	wire [7:0] readByte = (rIdx == VIC_IDX_PWR) ? pwr_q :
		(rIdx == VIC_IDX_TMR) ? tmr_q :
		(rIdx == VIC_IDX_SER) ? ser_q :
		(rIdx == VIC_IDX_IEN) ? ien_q :
		(rIdx == VIC_IDX_IPR) ? ipr_q :
		(rIdx == VIC_IDX_STAT) ? statByte : 8'h00;

	assign s_axi_awready = !awHeld_q;
	assign s_axi_wready = !wHeld_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////////
	// Requests and arbitration

	wire [VIC_NUM_SRC-1:0] reqRaw = {pwr_q[VIC_B_LVD_FLAG], 1'b0,
		ser_q[VIC_B_RX_DONE] | ser_q[VIC_B_TX_DONE],
		tmr_q[VIC_B_TF1], tmr_q[VIC_B_EXT1_FLAG], tmr_q[VIC_B_TF0], tmr_q[VIC_B_EXT0_FLAG]};
	wire [VIC_NUM_SRC-1:0] enBits = {ien_q[VIC_B_LOW_VOLT], 1'b0, ien_q[4:0]};
	wire [VIC_NUM_SRC-1:0] prioBits = {ipr_q[VIC_B_LOW_VOLT], 1'b0, ipr_q[4:0]};
	// Gate before arbitration so a masked source never wins
	wire [VIC_NUM_SRC-1:0] reqEn = reqRaw & enBits & {VIC_NUM_SRC{ien_q[VIC_B_GLOBAL_EN]}};
	wire [VIC_NUM_SRC-1:0] reqHigh = reqEn & prioBits;
	wire [VIC_NUM_SRC-1:0] reqLow = reqEn & ~prioBits;
	wire anyHigh = |reqHigh;
	wire [2:0] winIdx = anyHigh ? firstSet(reqHigh) : firstSet(reqLow);
	wire levelOk = !inProgHigh_q && (anyHigh || !inProgLow_q);
	wire pollBlock = !core.instrLastCycle || core.flashBusy || holdOff_q ||
		core.retiExec || wrIen || wrIpr;
	// No memory of a denied request: each poll looks at live flags only
	wire accept = (state_q == VIC_ST_IDLE) && (|reqEn) && levelOk && !pollBlock;
	wire [15:0] winVector = VIC_VEC_BASE + {10'h000, winIdx, 3'h0};

	wire clrExt0 = accept && winIdx == VIC_SRC_EXT0 && tmr_q[VIC_B_EXT0_EDGE];
	wire clrExt1 = accept && winIdx == VIC_SRC_EXT1 && tmr_q[VIC_B_EXT1_EDGE];
	wire clrTf0 = accept && winIdx == VIC_SRC_TMR0;
	wire clrTf1 = accept && winIdx == VIC_SRC_TMR1;
	wire edge0 = ext0Prev_q && !ext0RequestPinN;
	wire edge1 = ext1Prev_q && !ext1RequestPinN;

	////////////////////////////////////////////////////////////////////////////
	// Flag next values: write, then hardware clear, then hardware set

	always_comb begin
		tmr_d = wrTmr ? wByte : tmr_q;
		pwr_d = wrPwr ? wByte : pwr_q;
		ser_d = wrSer ? wByte : ser_q;
		if (clrTf0) begin
			tmr_d[VIC_B_TF0] = 1'b0;
		end
		if (clrTf1) begin
			tmr_d[VIC_B_TF1] = 1'b0;
		end
		if (clrExt0) begin
			tmr_d[VIC_B_EXT0_FLAG] = 1'b0;
		end
		if (clrExt1) begin
			tmr_d[VIC_B_EXT1_FLAG] = 1'b0;
		end
		// Set beats clear so an event in the clearing cycle survives
		if (periph.tmr0Rollover) begin
			tmr_d[VIC_B_TF0] = 1'b1;
		end
		if (periph.tmr1Rollover) begin
			tmr_d[VIC_B_TF1] = 1'b1;
		end
		if (periph.rxDone) begin
			ser_d[VIC_B_RX_DONE] = 1'b1;
		end
		if (periph.txDone) begin
			ser_d[VIC_B_TX_DONE] = 1'b1;
		end
		if (periph.lowVoltDetect) begin
			pwr_d[VIC_B_LVD_FLAG] = 1'b1;
		end
		// New trigger select applies at once, so a write that sets edge mode and the flag keeps the flag
		if (tmr_d[VIC_B_EXT0_EDGE]) begin
			tmr_d[VIC_B_EXT0_FLAG] = tmr_d[VIC_B_EXT0_FLAG] | edge0;
		end else begin
			tmr_d[VIC_B_EXT0_FLAG] = !ext0RequestPinN;
		end
		if (tmr_d[VIC_B_EXT1_EDGE]) begin
			tmr_d[VIC_B_EXT1_FLAG] = tmr_d[VIC_B_EXT1_FLAG] | edge1;
		end else begin
			tmr_d[VIC_B_EXT1_FLAG] = !ext1RequestPinN;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= VIC_RST_PWR;
			tmr_q <= VIC_RST_TMR;
			ser_q <= VIC_RST_SER;
			ien_q <= VIC_RST_IEN;
			ipr_q <= VIC_RST_IPR;
			ext0Prev_q <= 1'b1;
			ext1Prev_q <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			tmr_q <= tmr_d;
			ser_q <= ser_d;
			ien_q <= wrIen ? (wByte & VIC_IEN_MASK) : ien_q;
			ipr_q <= wrIpr ? (wByte & VIC_IPR_MASK) : ipr_q;
			ext0Prev_q <= ext0RequestPinN;
			ext1Prev_q <= ext1RequestPinN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Levels in progress and hold-off

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			inProgLow_q <= 1'b0;
			inProgHigh_q <= 1'b0;
		end else if (accept) begin
			inProgHigh_q <= inProgHigh_q | anyHigh;
			inProgLow_q <= inProgLow_q | !anyHigh;
		end else if (core.retiExec) begin
			// Return closes the innermost level only
			if (inProgHigh_q) begin
				inProgHigh_q <= 1'b0;
			end else begin
				inProgLow_q <= 1'b0;
			end
		end
	end

	// Holds polls off through the end of the next instruction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			holdOff_q <= 1'b0;
		end else if (core.retiExec || wrIen || wrIpr) begin
			holdOff_q <= 1'b1;
		end else if (core.instrLastCycle) begin
			holdOff_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Six-cycle hardware call

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= VIC_ST_IDLE;
			callCnt_q <= 3'h0;
			vector_q <= 16'h0000;
			pcSave_q <= 16'h0000;
		end else begin
			unique case (state_q)
				VIC_ST_IDLE: begin
					if (accept) begin
						state_q <= VIC_ST_CALL;
						callCnt_q <= 3'h0;
						vector_q <= winVector;
						pcSave_q <= core.pc;
					end
				end
				VIC_ST_CALL: begin
					callCnt_q <= callCnt_q + 3'h1;
					if (callCnt_q == VIC_CALL_CYCLES - 3'h1) begin
						state_q <= VIC_ST_IDLE;
					end
				end
			endcase
		end
	end

	// Low byte pushed first, then high; status word is not saved
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			callStart_q <= 1'b0;
			callDone_q <= 1'b0;
			pushValid_q <= 1'b0;
			pushByte_q <= 8'h00;
		end else begin
			callStart_q <= accept;
			callDone_q <= (state_q == VIC_ST_CALL) && (callCnt_q == VIC_CALL_CYCLES - 3'h2);
			pushValid_q <= accept || (state_q == VIC_ST_CALL && callCnt_q == 3'h0);
			pushByte_q <= accept ? core.pc[7:0] : pcSave_q[15:8];
		end
	end

	assign coreOut.callStart = callStart_q;
	assign coreOut.callBusy = (state_q == VIC_ST_CALL);
	assign coreOut.callDone = callDone_q;
	assign coreOut.vector = vector_q;
	assign coreOut.pushValid = pushValid_q;
	assign coreOut.pushByte = pushByte_q;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= VIC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_q) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end
			if (s_axi_wvalid && !wHeld_q) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end
			if (doWrite) begin
				bvalid_q <= 1'b1;
				bresp_q <= wMapped ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= VIC_RESP_OKAY;
		end else if (readTake) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h000000, isMapped(s_axi_araddr) ? readByte : 8'h00};
			rresp_q <= isMapped(s_axi_araddr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule

// ===== design/vic_pkg.sv
// Shared constants, states and carriers of the vectored interrupt controller
package vic_pkg;

	localparam int unsigned VIC_ADDR_W = 12;
	localparam int unsigned VIC_NUM_SRC = 7;

	// Register indices; byte address is four times the index
	localparam logic [7:0] VIC_IDX_PWR = 8'h87;
	localparam logic [7:0] VIC_IDX_TMR = 8'h88;
	localparam logic [7:0] VIC_IDX_SER = 8'h98;
	localparam logic [7:0] VIC_IDX_IEN = 8'hA8;
	localparam logic [7:0] VIC_IDX_IPR = 8'hB8;
	localparam logic [7:0] VIC_IDX_STAT = 8'hC0;

	localparam logic [7:0] VIC_RST_PWR = 8'h10;
	localparam logic [7:0] VIC_RST_TMR = 8'h00;
	localparam logic [7:0] VIC_RST_SER = 8'h00;
	localparam logic [7:0] VIC_RST_IEN = 8'h00;
	localparam logic [7:0] VIC_RST_IPR = 8'h00;
	localparam logic [7:0] VIC_IEN_MASK = 8'hDF;
	localparam logic [7:0] VIC_IPR_MASK = 8'h5F;

	// Field positions
	localparam int unsigned VIC_B_GLOBAL_EN = 7;
	localparam int unsigned VIC_B_LOW_VOLT = 6;
	localparam int unsigned VIC_B_LVD_FLAG = 5;
	localparam int unsigned VIC_B_TF1 = 7;
	localparam int unsigned VIC_B_TF0 = 5;
	localparam int unsigned VIC_B_EXT1_FLAG = 3;
	localparam int unsigned VIC_B_EXT1_EDGE = 2;
	localparam int unsigned VIC_B_EXT0_FLAG = 1;
	localparam int unsigned VIC_B_EXT0_EDGE = 0;
	localparam int unsigned VIC_B_TX_DONE = 1;
	localparam int unsigned VIC_B_RX_DONE = 0;

	// Source slots in polling order
	localparam logic [2:0] VIC_SRC_EXT0 = 3'h0;
	localparam logic [2:0] VIC_SRC_TMR0 = 3'h1;
	localparam logic [2:0] VIC_SRC_EXT1 = 3'h2;
	localparam logic [2:0] VIC_SRC_TMR1 = 3'h3;

	localparam logic [15:0] VIC_VEC_BASE = 16'h0003;
	localparam logic [2:0] VIC_CALL_CYCLES = 3'h6;

	localparam logic [1:0] VIC_RESP_OKAY = 2'h0;
	localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		VIC_ST_IDLE = 2'b01,
		VIC_ST_CALL = 2'b10
	} vic_state_t;

	typedef struct packed {
		logic tmr0Rollover;
		logic tmr1Rollover;
		logic rxDone;
		logic txDone;
		logic lowVoltDetect;
	} vic_periph_t;

	typedef struct packed {
		logic instrLastCycle;
		logic retiExec;
		logic flashBusy;
		logic [15:0] pc;
	} vic_core_in_t;

	typedef struct packed {
		logic callStart;
		logic callBusy;
		logic callDone;
		logic [15:0] vector;
		logic pushValid;
		logic [7:0] pushByte;
	} vic_core_out_t;

endpackage

// ===== sim/vic_irq_ctrl_props.sv
// Concurrent checks on the interrupt controller ports
`timescale 1ns/10ps
module vic_irq_ctrl_props
	import vic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire vic_core_in_t core,
	input wire vic_core_out_t coreOut
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_busy;
		coreOut.callBusy [*6] ##1 !coreOut.callBusy;
	endsequence
	sequence s_push;
		coreOut.pushValid && coreOut.pushByte == core.pc[7:0] ##1
			coreOut.pushValid && coreOut.pushByte == core.pc[15:8] ##1 !coreOut.pushValid;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	chk_call_length: assert property (coreOut.callStart |-> s_busy)
		else $error("call busy not six cycles");
	chk_call_done: assert property (coreOut.callStart |-> !coreOut.callDone ##5 coreOut.callDone)
		else $error("call done at wrong cycle");
	chk_push_order: assert property (coreOut.callStart |-> s_push)
		else $error("counter push wrong");
	chk_vector_legal: assert property (coreOut.callStart |-> coreOut.vector inside
		{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h0033})
		else $error("vector outside table");
	chk_vector_stable: assert property (coreOut.callBusy && !coreOut.callStart |-> $stable(coreOut.vector))
		else $error("vector moved during call");
	chk_poll_gate: assert property (coreOut.callStart |-> $past(core.instrLastCycle) &&
		!$past(core.flashBusy) && !$past(core.retiExec))
		else $error("call accepted while blocked");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule

bind vic_irq_ctrl vic_irq_ctrl_props u_props (.sys_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core, .coreOut);

// ===== sim/vic_core_model.sv
// Behavioural processor core that polls, calls and returns
`timescale 1ns/10ps
module vic_core_model
	import vic_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic retiReq,
	input wire logic flashReq,
	input wire vic_core_out_t coreOut,
	output vic_core_in_t core
);
	logic [1:0] phase_q;
	logic lastCycle;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end
	// Slow mode stands for four-cycle instructions; a call ends on its own last cycle
	assign lastCycle = coreOut.callBusy ? coreOut.callDone : (!slow || phase_q == 2'h0);
	// Fixed counter value, since no stack is modelled
	assign core = {lastCycle, retiReq & lastCycle & !coreOut.callBusy, flashReq, 16'h1234};
endmodule

// ===== sim/tb.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
module tb;
	import vic_pkg::*;
	localparam logic W = 1'h1;
	localparam logic R = 1'h0;
	logic sys_clk = 1'h0, rst_n = 1'h0, awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
	logic ext0PinN = 1'h1, ext1PinN = 1'h1, slow = 1'h0, retiReq = 1'h0, flashReq = 1'h0;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
	logic [31:0] wData = 32'h0, rData;
	logic [1:0] bResp, rResp;
	vic_periph_t periph = '0;
	vic_core_in_t core;
	vic_core_out_t coreOut;
	int failures = 0, checks = 0;

	always #2.5 sys_clk = ~sys_clk;

	vic_irq_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .ext0RequestPinN(ext0PinN), .ext1RequestPinN(ext1PinN),
		.periph(periph), .core(core), .coreOut(coreOut));
	vic_core_model core_mdl (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .retiReq(retiReq),
		.flashReq(flashReq), .coreOut(coreOut), .core(core));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Handshakes are sampled 1 ns after an edge, so the next edge sees the same values
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
		logic ta, tw, tr;
		logic [31:0] d;
		logic [1:0] r;
		awAddr <= {2'h0, idx, 2'h0};
		arAddr <= {2'h0, idx, 2'h0};
		wData <= {24'h0, e};
		awValid <= w;
		wValid <= w;
		bReady <= w;
		arValid <= !w;
		rReady <= !w;
		for (int n = 0; n < 50; n++) begin
			#1;
			ta = (awValid & awReady) | (arValid & arReady);
			tw = wValid & wReady;
			tr = (bValid & bReady) | (rValid & rReady);
			d = rData;
			r = w ? bResp : rResp;
			@(posedge sys_clk);
			if (ta) begin
				awValid <= 1'h0;
				arValid <= 1'h0;
			end
			if (tw)
				wValid <= 1'h0;
			if (tr) begin
				bReady <= 1'h0;
				rReady <= 1'h0;
				chk("response", {30'h0, r}, {30'h0, er});
				if (!w)
					chk("read data", d, {24'h0, e});
				break;
			end
		end
		#1;
	endtask

	task automatic waitCall(input logic [15:0] v);
		int n;
		for (n = 0; n < 80 && coreOut.callStart !== 1'h1; n++)
			#5;
		chk("vector", n < 80 ? {16'h0, coreOut.vector} : 32'hX, {16'h0, v});
	endtask

	task automatic noCall();
		repeat (20) begin
			#5;
			chk("no call", {31'h0, coreOut.callStart}, 32'h0);
		end
	endtask

	task automatic return_from_irq_op();
		retiReq <= 1'h1;
		#1;
		for (int n = 0; n < 40 && core.retiExec !== 1'h1; n++)
			#5;
		@(posedge sys_clk);
		retiReq <= 1'h0;
		#1;
	endtask

	task automatic pulse(input vic_periph_t p);
		periph <= p;
		@(posedge sys_clk);
		periph <= '0;
		#1;
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic testRegs();
		bus(R, VIC_IDX_PWR, 8'h10);
		bus(R, VIC_IDX_TMR, 8'h00);
		bus(R, VIC_IDX_SER, 8'h00);
		bus(R, VIC_IDX_IPR, 8'h00);
		bus(W, VIC_IDX_IEN, 8'hFF);
		bus(R, VIC_IDX_IEN, 8'hDF);
		bus(W, 8'h10, 8'hFF, VIC_RESP_SLVERR);
		bus(R, 8'h10, 8'h00, VIC_RESP_SLVERR);
		bus(W, VIC_IDX_IEN, 8'h00);
	endtask

	task automatic testArbitrate();
		bus(W, VIC_IDX_TMR, 8'h23);
		bus(W, VIC_IDX_IEN, 8'h03);
		noCall();
		bus(W, VIC_IDX_IEN, 8'h83);
		waitCall(16'h0003);
		bus(R, VIC_IDX_TMR, 8'h21);
		bus(W, VIC_IDX_IPR, 8'h10);
		bus(W, VIC_IDX_SER, 8'h01);
		bus(W, VIC_IDX_IEN, 8'h93);
		waitCall(16'h0023);
		bus(R, VIC_IDX_SER, 8'h01);
		bus(W, VIC_IDX_SER, 8'h00);
		noCall();
		bus(R, VIC_IDX_STAT, 8'h06);
		return_from_irq_op();
		noCall();
		bus(R, VIC_IDX_STAT, 8'h02);
		return_from_irq_op();
		waitCall(16'h000B);
		bus(R, VIC_IDX_TMR, 8'h01);
		return_from_irq_op();
	endtask

	task automatic testLevel();
		bus(W, VIC_IDX_IEN, 8'hC0);
		bus(W, VIC_IDX_PWR, 8'h30);
		waitCall(16'h0033);
		bus(R, VIC_IDX_PWR, 8'h30);
		bus(W, VIC_IDX_PWR, 8'h10);
		return_from_irq_op();
		bus(W, VIC_IDX_IEN, 8'h84);
		ext1PinN <= 1'h0;
		waitCall(16'h0013);
		bus(R, VIC_IDX_TMR, 8'h09);
		ext1PinN <= 1'h1;
		// Level flag follows the pin one edge later
		@(posedge sys_clk);
		#1;
		bus(R, VIC_IDX_TMR, 8'h01);
		return_from_irq_op();
		noCall();
	endtask

	task automatic testEdge();
		bus(W, VIC_IDX_TMR, 8'h05);
		bus(W, VIC_IDX_IEN, 8'h8C);
		flashReq <= 1'h1;
		ext1PinN <= 1'h0;
		pulse(5'h08);
		noCall();
		flashReq <= 1'h0;
		waitCall(16'h0013);
		return_from_irq_op();
		waitCall(16'h001B);
		bus(R, VIC_IDX_TMR, 8'h05);
		ext1PinN <= 1'h1;
		return_from_irq_op();
	endtask

	task automatic testSoft();
		slow <= 1'h1;
		bus(W, VIC_IDX_IEN, 8'h08);
		bus(W, VIC_IDX_TMR, 8'h85);
		bus(W, VIC_IDX_TMR, 8'h05);
		bus(W, VIC_IDX_IEN, 8'h88);
		noCall();
		bus(W, VIC_IDX_TMR, 8'h85);
		waitCall(16'h001B);
		return_from_irq_op();
		bus(W, VIC_IDX_IEN, 8'h92);
		pulse(5'h06);
		waitCall(16'h0023);
		bus(R, VIC_IDX_SER, 8'h03);
		bus(W, VIC_IDX_SER, 8'h00);
		return_from_irq_op();
		pulse(5'h10);
		waitCall(16'h000B);
		return_from_irq_op();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		#1;
		testRegs();
		testArbitrate();
		testLevel();
		testEdge();
		testSoft();
		end_of_test();
	end

	initial begin
		#50000;
		failures++;
		end_of_test();
	end
endmodule
